// ### core/sbs_top.sv
// sbs_top: status flags, bank/pointer select, indirect port, page logic.
// assumes core instruction logic drives the event and alu inputs, one
// cycle each, and an AXI4-Lite master reaches the registers.
`default_nettype none
module sbs_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core events, one-cycle pulses
	input wire logic wake_event,
	input wire logic other_reset_event,
	input wire logic sleep_instruction,
	input wire logic watchdog_clear_instruction,
	input wire logic watchdog_timeout,
	// alu flag update
	input wire logic alu_flags_we,
	input wire logic alu_zero,
	input wire logic alu_half_carry,
	input wire logic alu_carry,
	// program flow
	input wire logic pc_load,
	input wire logic [9:0] pc_load_low,
	input wire logic return_pop,
	input wire logic [10:0] return_addr,
	// state shown to the core
	output logic [10:0] program_counter,
	output logic [7:0] status_out,
	output logic control_segment_select
);
	// storage channel
	sbs_mem_if mem ();
	sbs_gpr #(.NBANK(2)) u_gpr (.aclk(aclk), .aresetn(aresetn), .mem(mem));
	// registers
	logic [7:0] status_flags; // status word
	logic [6:0] bank_pointer_select; // bit7 not stored, reads zero
	logic [10:0] pc_q; // program counter register
	logic [5:0] core_addr; // data-space address used by the data port
	logic [7:0] next_status;
	logic [6:0] next_bank;
	logic [10:0] next_pc;
	logic [5:0] next_core_addr;
	// axi state
	logic aw_hold, w_hold, bvalid_q, rvalid_q, arready_q;
	// ready flops mirror the hold flags so the pins come from a flop
	logic awready_q, wready_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	// decoded write
	logic do_write;
	logic [7:0] wbyte;
	logic [5:0] phys;
	sbs_pkg::sbs_seg_e seg;

	// segment decode of the current core address
	sbs_segdec u_seg (.seg_sel(status_flags[sbs_pkg::ST_SEG]),
		.addr(core_addr), .seg(seg));

	// resolve address 0x00 through the pointer
	function automatic logic [5:0] resolve(input logic [5:0] a,
		input logic [6:0] bs);
		if (a == sbs_pkg::ADDR_INDIRECT)
			return bs[sbs_pkg::BS_PTR_HI:0];
		return a;
	endfunction

	// read value of a physical data-space address
	function automatic logic [7:0] core_read(input logic [5:0] a,
		input logic [7:0] st, input logic [6:0] bs, input logic [7:0] gp,
		input logic [10:0] pc);
		case (a)
			sbs_pkg::ADDR_STATUS: core_read = st;
			sbs_pkg::ADDR_BANKSEL: core_read = {1'b0, bs};
			6'h02: core_read = pc[7:0];
			default: core_read = (a >= sbs_pkg::ADDR_GP_LO) ? gp : 8'h00;
		endcase
	endfunction

	assign phys = resolve(core_addr, bank_pointer_select);
	assign mem.addr = phys;
	assign mem.bank = bank_pointer_select[sbs_pkg::BS_BANK];
	assign do_write = aw_hold && w_hold && !bvalid_q;
	assign wbyte = w_data_q[7:0];
	assign mem.wdata = wbyte;
	assign mem.we = do_write && aw_addr_q == sbs_pkg::AXI_CORE_DATA
		&& w_strb_q[0] && phys >= sbs_pkg::ADDR_GP_LO;

	// status, bank select, pc and address next-state
	always_comb begin
		next_status = status_flags;
		next_bank = bank_pointer_select;
		next_pc = pc_q;
		next_core_addr = core_addr;
		// software writes; only segment, page and the z, dc and c bits are writable
		if (do_write && w_strb_q[0]) begin
			if (aw_addr_q == sbs_pkg::AXI_STATUS
				|| (aw_addr_q == sbs_pkg::AXI_CORE_DATA
				&& phys == sbs_pkg::ADDR_STATUS)) begin
				next_status[sbs_pkg::ST_SEG] = wbyte[sbs_pkg::ST_SEG];
				next_status[sbs_pkg::ST_PAGE] = wbyte[sbs_pkg::ST_PAGE];
				next_status[2:0] = wbyte[2:0];
			end
			if (aw_addr_q == sbs_pkg::AXI_BANKSEL
				|| (aw_addr_q == sbs_pkg::AXI_CORE_DATA
				&& phys == sbs_pkg::ADDR_BANKSEL))
				next_bank = wbyte[6:0];
			if (aw_addr_q == sbs_pkg::AXI_CORE_ADDR)
				next_core_addr = wbyte[5:0];
			if (aw_addr_q == sbs_pkg::AXI_SEGSEL)
				next_status[sbs_pkg::ST_SEG] = wbyte[0];
		end
		// alu flags win over a software write in the same cycle
		if (alu_flags_we) begin
			next_status[sbs_pkg::ST_Z] = alu_zero;
			next_status[sbs_pkg::ST_DC] = alu_half_carry;
			next_status[sbs_pkg::ST_C] = alu_carry;
		end
		// reset cause
		if (other_reset_event) next_status[sbs_pkg::ST_RST] = 1'b0;
		if (wake_event) next_status[sbs_pkg::ST_RST] = 1'b1;
		// time-out and power-down: the setting event wins
		if (watchdog_timeout) next_status[sbs_pkg::ST_TO] = 1'b0;
		if (sleep_instruction) begin
			next_status[sbs_pkg::ST_TO] = 1'b1;
			next_status[sbs_pkg::ST_PD] = 1'b0;
		end
		if (watchdog_clear_instruction) begin
			next_status[sbs_pkg::ST_TO] = 1'b1;
			next_status[sbs_pkg::ST_PD] = 1'b1;
		end
		// program counter: returns restore the popped page untouched
		if (return_pop) begin
			next_pc = return_addr;
		end else if (pc_load) begin
			next_pc = {status_flags[sbs_pkg::ST_PAGE], pc_load_low};
		end else if (do_write && aw_addr_q == sbs_pkg::AXI_PC) begin
			next_pc = {status_flags[sbs_pkg::ST_PAGE], w_data_q[9:0]};
		end
	end

	// axi channel next-state
	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_aw_addr = aw_addr_q;
		next_w_data = w_data_q;
		next_w_strb = w_strb_q;
		next_bvalid = bvalid_q;
		next_bresp = bresp_q;
		next_rvalid = rvalid_q;
		next_rresp = rresp_q;
		next_rdata = rdata_q;
		// capture address and data in either order
		if (s_axi_awvalid && !aw_hold) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		// both present: perform and answer
		if (do_write) begin
			next_bvalid = 1'b1;
			case (aw_addr_q)
				sbs_pkg::AXI_STATUS, sbs_pkg::AXI_BANKSEL,
				sbs_pkg::AXI_CORE_ADDR, sbs_pkg::AXI_CORE_DATA,
				sbs_pkg::AXI_PC, sbs_pkg::AXI_SEGSEL:
					next_bresp = sbs_pkg::RESP_OKAY;
				default: next_bresp = sbs_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
		end
		// read: one cycle from accept to rvalid
		if (s_axi_arvalid && arready_q) begin
			next_rvalid = 1'b1;
			next_rresp = sbs_pkg::RESP_OKAY;
			case (s_axi_araddr)
				sbs_pkg::AXI_STATUS: next_rdata = {24'h0, status_flags};
				sbs_pkg::AXI_BANKSEL:
					next_rdata = {24'h0, 1'b0, bank_pointer_select};
				sbs_pkg::AXI_CORE_ADDR: next_rdata = {26'h0, core_addr};
				sbs_pkg::AXI_CORE_DATA: next_rdata = {24'h0,
					core_read(phys, status_flags, bank_pointer_select,
					mem.rdata, pc_q)};
				sbs_pkg::AXI_PC: next_rdata = {21'h0, pc_q};
				sbs_pkg::AXI_SEGSEL: next_rdata = {30'h0, seg};
				default: begin
					next_rdata = 32'h0;
					next_rresp = sbs_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// registering of all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flags <= sbs_pkg::STATUS_RST;
			bank_pointer_select <= sbs_pkg::BANKSEL_RST[6:0];
			pc_q <= 11'h000;
			core_addr <= 6'h00;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h0;
			arready_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			program_counter <= 11'h000;
			status_out <= sbs_pkg::STATUS_RST;
			control_segment_select <= 1'b0;
		end else begin
			status_flags <= next_status;
			bank_pointer_select <= next_bank;
			pc_q <= next_pc;
			core_addr <= next_core_addr;
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			aw_addr_q <= next_aw_addr;
			w_data_q <= next_w_data;
			w_strb_q <= next_w_strb;
			bvalid_q <= next_bvalid;
			bresp_q <= next_bresp;
			rvalid_q <= next_rvalid;
			rresp_q <= next_rresp;
			rdata_q <= next_rdata;
			// one read outstanding: ready only while idle
			arready_q <= !next_rvalid && !(s_axi_arvalid && arready_q);
			awready_q <= !next_aw_hold;
			wready_q <= !next_w_hold;
			program_counter <= next_pc;
			status_out <= next_status;
			control_segment_select <= next_status[sbs_pkg::ST_SEG];
		end
	end

	// flop-driven bus outputs
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
endmodule // sbs_top
`default_nettype wire

// ### core/sbs_pkg.sv
// sbs_pkg: constants for the status and bank-select register block.
// assumes a single aclk domain and an AXI4-Lite master outside.
`default_nettype none
package sbs_pkg;
	// core data-space addresses (6-bit)
	localparam logic [5:0] ADDR_INDIRECT = 6'h00;
	localparam logic [5:0] ADDR_STATUS = 6'h03;
	localparam logic [5:0] ADDR_BANKSEL = 6'h04;
	localparam logic [5:0] ADDR_SEG_LO = 6'h05;
	localparam logic [5:0] ADDR_SEG0_HI = 6'h0f;
	localparam logic [5:0] ADDR_SEG1_HI = 6'h0c;
	localparam logic [5:0] ADDR_GP_LO = 6'h10;
	localparam logic [5:0] ADDR_BANK_LO = 6'h20;
	// status bit positions
	localparam int ST_RST = 7;
	localparam int ST_SEG = 6;
	localparam int ST_PAGE = 5;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int ST_Z = 2;
	localparam int ST_DC = 1;
	localparam int ST_C = 0;
	// bank-select bit positions
	localparam int BS_BANK = 6;
	localparam int BS_PTR_HI = 5;
	// program counter
	localparam int PC_W = 11;
	localparam int PC_PAGE = 10;
	// status reset value: time-out and power-down set at power-on
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] BANKSEL_RST = 8'h00;
	// AXI4-Lite byte addresses of the software-visible words
	localparam logic [7:0] AXI_STATUS = 8'h0c;
	localparam logic [7:0] AXI_BANKSEL = 8'h10;
	localparam logic [7:0] AXI_CORE_ADDR = 8'h20;
	localparam logic [7:0] AXI_CORE_DATA = 8'h24;
	localparam logic [7:0] AXI_PC = 8'h28;
	localparam logic [7:0] AXI_SEGSEL = 8'h2c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// segment decode results
	typedef enum logic [1:0] {
		SBS_SEG_NONE = 2'b00,
		SBS_SEG_0 = 2'b01,
		SBS_SEG_1 = 2'b10
	} sbs_seg_e;
endpackage
`default_nettype wire

// ### core/sbs_mem_if.sv
// sbs_mem_if: one data-space access from the top into the storage module.
// assumes both ends run on aclk.
`default_nettype none
interface sbs_mem_if;
	logic [5:0] addr; // resolved physical address
	logic bank; // bank for 0x20-0x3f
	logic we; // write strobe
	logic [7:0] wdata; // write data
	logic [7:0] rdata; // read data of addr
	modport master (output addr, output bank, output we, output wdata,
		input rdata);
	modport slave (input addr, input bank, input we, input wdata,
		output rdata);
endinterface
`default_nettype wire

// ### core/sbs_gpr.sv
// sbs_gpr: general registers, common 0x10-0x1f and banked 0x20-0x3f.
// assumes the top never presents addresses below 0x10 as writes here.
`default_nettype none
module sbs_gpr #(
	parameter int NBANK = 2
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// access port
	sbs_mem_if.slave mem
);
	// elaboration-time refusal: the bank index is a single bit
	if (NBANK != 2) begin : g_nbank_check
		$error("sbs_gpr supports two banks only");
	end
	// flops: 16 common + 32 per bank
	logic [7:0] common_q [16];
	logic [7:0] bank_q [NBANK][32];
	logic [7:0] next_common [16];
	logic [7:0] next_bank [NBANK][32];
	// next-state: only the addressed word changes
	always_comb begin
		next_common = common_q;
		next_bank = bank_q;
		if (mem.we && mem.addr >= sbs_pkg::ADDR_BANK_LO) begin
			next_bank[mem.bank][mem.addr[4:0]] = mem.wdata;
		end else if (mem.we && mem.addr >= sbs_pkg::ADDR_GP_LO) begin
			next_common[mem.addr[3:0]] = mem.wdata;
		end
	end
	// registering
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 16; i++) common_q[i] <= 8'h00;
			for (int b = 0; b < NBANK; b++)
				for (int i = 0; i < 32; i++) bank_q[b][i] <= 8'h00;
		end else begin
			common_q <= next_common;
			bank_q <= next_bank;
		end
	end
	// read mux: banked region duplicated, common region shared
	always_comb begin
		if (mem.addr >= sbs_pkg::ADDR_BANK_LO) begin
			mem.rdata = bank_q[mem.bank][mem.addr[4:0]];
		end else if (mem.addr >= sbs_pkg::ADDR_GP_LO) begin
			mem.rdata = common_q[mem.addr[3:0]];
		end else begin
			mem.rdata = 8'h00;
		end
	end
endmodule // sbs_gpr
`default_nettype wire

// ### core/sbs_segdec.sv
// sbs_segdec: decodes a control-register address against the segment bit.
// assumes a purely combinational use by the top.
`default_nettype none
module sbs_segdec (
	// request
	input wire logic seg_sel,
	input wire logic [5:0] addr,
	// result
	output sbs_pkg::sbs_seg_e seg
);
	// segment 1 spans fewer addresses; the rest read as reserved
	always_comb begin
		seg = sbs_pkg::SBS_SEG_NONE;
		if (!seg_sel) begin
			if (addr >= sbs_pkg::ADDR_SEG_LO && addr <= sbs_pkg::ADDR_SEG0_HI)
				seg = sbs_pkg::SBS_SEG_0;
		end else begin
			if (addr >= sbs_pkg::ADDR_SEG_LO && addr <= sbs_pkg::ADDR_SEG1_HI)
				seg = sbs_pkg::SBS_SEG_1;
		end
	end
endmodule // sbs_segdec
`default_nettype wire

// ### tb/sbs_top_properties.sv
// sbs_top_properties: timing checks on the core side of sbs_top.
// assumes it is bound into sbs_top and sees only its ports.
`default_nettype none
module sbs_top_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core events
	input wire logic wake_event,
	input wire logic other_reset_event,
	input wire logic sleep_instruction,
	input wire logic watchdog_clear_instruction,
	input wire logic watchdog_timeout,
	// alu and program flow
	input wire logic alu_flags_we,
	input wire logic alu_zero,
	input wire logic alu_half_carry,
	input wire logic alu_carry,
	input wire logic pc_load,
	input wire logic [9:0] pc_load_low,
	input wire logic return_pop,
	input wire logic [10:0] return_addr,
	// observed state
	input wire logic [10:0] program_counter,
	input wire logic [7:0] status_out,
	input wire logic control_segment_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// a jump only counts when no return wins the same edge
	sequence s_load;
		pc_load && !return_pop;
	endsequence
	sequence s_pop;
		return_pop;
	endsequence
	property p_wake;
		wake_event |=> status_out[7];
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake did not set cause bit");
	property p_other;
		other_reset_event && !wake_event |=> !status_out[7];
	endproperty
	a_other: assert property (p_other)
		else $error("other reset did not clear cause bit");
	property p_sleep;
		sleep_instruction && !watchdog_clear_instruction
			|=> status_out[4:3] == 2'h2;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep flags wrong");
	property p_wdc;
		watchdog_clear_instruction && !sleep_instruction
			|=> status_out[4:3] == 2'h3;
	endproperty
	a_wdc: assert property (p_wdc)
		else $error("watchdog clear flags wrong");
	property p_to;
		watchdog_timeout && !sleep_instruction &&
			!watchdog_clear_instruction |=> !status_out[4];
	endproperty
	a_to: assert property (p_to)
		else $error("timeout did not clear flag");
	property p_alu;
		alu_flags_we |=> status_out[2:0] ==
			{$past(alu_zero), $past(alu_half_carry), $past(alu_carry)};
	endproperty
	a_alu: assert property (p_alu)
		else $error("alu flags not taken");
	property p_load;
		s_load |=> program_counter ==
			{$past(status_out[5]), $past(pc_load_low)};
	endproperty
	a_load: assert property (p_load)
		else $error("page bit not copied on jump");
	property p_pop;
		s_pop |=> program_counter == $past(return_addr) &&
			$stable(status_out[5]);
	endproperty
	a_pop: assert property (p_pop)
		else $error("return wrong or page bit moved");
	// reset is the antecedent here, so this one is never disabled
	property p_rst;
		disable iff (1'h0) !aresetn |=> program_counter == 11'h000 &&
			status_out == sbs_pkg::STATUS_RST;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset state wrong");
	property p_seg;
		control_segment_select == status_out[6];
	endproperty
	a_seg: assert property (p_seg)
		else $error("segment select differs from status");
	// hardware-only bits may move only after their own events
	property p_hw;
		$changed(status_out[4:3]) |-> $past(sleep_instruction) ||
			$past(watchdog_clear_instruction) || $past(watchdog_timeout);
	endproperty
	a_hw: assert property (p_hw)
		else $error("power flags moved without event");
	property p_hwr;
		$changed(status_out[7]) |->
			$past(wake_event) || $past(other_reset_event);
	endproperty
	a_hwr: assert property (p_hwr)
		else $error("cause bit moved without event");
endmodule // sbs_top_properties
`default_nettype wire

// ### tb/status_and_bank_select_bench.sv
// status_and_bank_select_bench: register and core-event tests of sbs_top.
// assumes sbs_pkg and the design are compiled before this file.
`default_nettype none
module status_and_bank_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0; // 100 MHz
	logic aresetn = 1'h0; // sync, active low
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, control_segment_select;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [4:0] ev = 5'h00; // wake, other, sleep, wdt clear, timeout
	logic [3:0] alu = 4'h0; // we, zero, half carry, carry
	logic pc_load = 1'h0, return_pop = 1'h0;
	logic [9:0] pc_load_low = 10'h000;
	logic [10:0] return_addr = 11'h000, program_counter;
	logic [7:0] status_out;
	int n_fail = 0, check_count = 0;
	// segment table: select, core address, decode
	logic sg [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
	logic [5:0] sa [6] = '{6'h05, 6'h0f, 6'h10, 6'h05, 6'h0c, 6'h0d};
	logic [31:0] se [6] = '{32'h1, 32'h1, 32'h0, 32'h2, 32'h2, 32'h0};
	// cause and power bits after each event pulse
	logic [31:0] ex [5] = '{32'h98, 32'h18, 32'h10, 32'h18, 32'h08};
	always #5 aclk = ~aclk;
	sbs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.wake_event(ev[4]), .other_reset_event(ev[3]),
		.sleep_instruction(ev[2]), .watchdog_clear_instruction(ev[1]),
		.watchdog_timeout(ev[0]), .alu_flags_we(alu[3]),
		.alu_zero(alu[2]), .alu_half_carry(alu[1]), .alu_carry(alu[0]),
		.pc_load, .pc_load_low, .return_pop, .return_addr,
		.program_counter, .status_out, .control_segment_select);
	task automatic wrap_up;
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// write: both channels offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic ka, kw, kb;
		kb = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!kb) begin
			// ready flops are settled mid-cycle, sampled at next edge
			@(negedge aclk);
			ka = s_axi_awvalid && s_axi_awready;
			kw = s_axi_wvalid && s_axi_wready;
			kb = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge aclk);
			if (ka) s_axi_awvalid <= 1'h0;
			if (kw) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		chk(32'(rr), 32'(er));
	endtask
	// read: data is compared only when an okay answer is expected
	task automatic axr(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ka, kb;
		kb = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!kb) begin
			@(negedge aclk);
			ka = s_axi_arvalid && s_axi_arready;
			kb = s_axi_rvalid;
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (ka) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
		chk(32'(rr), 32'(er));
		if (er === sbs_pkg::RESP_OKAY) chk(rd, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, 4'hf, sbs_pkg::RESP_OKAY);
	endtask
	task automatic rdk(input logic [7:0] a, input logic [31:0] e);
		axr(a, e, sbs_pkg::RESP_OKAY);
	endtask
	task automatic ca(input logic [5:0] a);
		wr(sbs_pkg::AXI_CORE_ADDR, {26'h0, a});
	endtask
	// one-cycle core pulse, then settle to mid-cycle for checks
	task automatic hit(input logic [4:0] e, input logic [3:0] f,
		input logic pl, input logic rp, input logic [9:0] lo,
		input logic [10:0] ra);
		@(posedge aclk);
		ev <= e;
		alu <= f;
		pc_load <= pl;
		return_pop <= rp;
		pc_load_low <= lo;
		return_addr <= ra;
		@(posedge aclk);
		ev <= 5'h00;
		alu <= 4'h0;
		pc_load <= 1'h0;
		return_pop <= 1'h0;
		@(negedge aclk);
	endtask
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rdk(sbs_pkg::AXI_STATUS, 32'h18);
		rdk(sbs_pkg::AXI_PC, 32'h0);
		wr(sbs_pkg::AXI_BANKSEL, 32'hff);
		rdk(sbs_pkg::AXI_BANKSEL, 32'h7f);
		// same address in both banks, plus one common register
		wr(sbs_pkg::AXI_BANKSEL, 32'h00);
		ca(6'h25);
		wr(sbs_pkg::AXI_CORE_DATA, 32'ha1);
		ca(6'h15);
		wr(sbs_pkg::AXI_CORE_DATA, 32'h5c);
		wr(sbs_pkg::AXI_BANKSEL, 32'h40);
		ca(6'h25);
		wr(sbs_pkg::AXI_CORE_DATA, 32'hb2);
		ca(6'h15);
		rdk(sbs_pkg::AXI_CORE_DATA, 32'h5c);
		wr(sbs_pkg::AXI_BANKSEL, 32'h00);
		ca(6'h25);
		rdk(sbs_pkg::AXI_CORE_DATA, 32'ha1);
		// indirect port through pointer 0x25 in bank 1
		wr(sbs_pkg::AXI_BANKSEL, 32'h65);
		ca(6'h00);
		rdk(sbs_pkg::AXI_CORE_DATA, 32'hb2);
		wr(sbs_pkg::AXI_CORE_DATA, 32'hc3);
		ca(6'h25);
		rdk(sbs_pkg::AXI_CORE_DATA, 32'hc3);
		for (int i = 0; i < 6; i++) begin
			wr(sbs_pkg::AXI_SEGSEL, {31'h0, sg[i]});
			ca(sa[i]);
			rdk(sbs_pkg::AXI_SEGSEL, se[i]);
			chk(32'(control_segment_select), 32'(sg[i]));
		end
		wr(sbs_pkg::AXI_STATUS, 32'h20);
		hit(5'h00, 4'h0, 1'h1, 1'h0, 10'h155, 11'h000);
		chk(32'(program_counter), 32'h555);
		wr(sbs_pkg::AXI_PC, 32'h3ab);
		rdk(sbs_pkg::AXI_PC, 32'h7ab);
		hit(5'h00, 4'h0, 1'h0, 1'h1, 10'h000, 11'h123);
		chk(32'(program_counter), 32'h123);
		chk(32'(status_out[5]), 32'h1);
		wr(sbs_pkg::AXI_STATUS, 32'h00);
		hit(5'h00, 4'h0, 1'h1, 1'h0, 10'h2aa, 11'h000);
		chk(32'(program_counter), 32'h2aa);
		for (int i = 0; i < 5; i++) begin
			hit(5'(5'h10 >> i), 4'h0, 1'h0, 1'h0, 10'h000, 11'h000);
			chk(32'(status_out & 8'h98), ex[i]);
		end
		hit(5'h00, 4'hd, 1'h0, 1'h0, 10'h000, 11'h000);
		chk(32'(status_out[2:0]), 32'h5);
		hit(5'h00, 4'ha, 1'h0, 1'h0, 10'h000, 11'h000);
		chk(32'(status_out[2:0]), 32'h2);
		// software cannot touch cause, time-out or power-down bits
		wr(sbs_pkg::AXI_STATUS, 32'hff);
		rdk(sbs_pkg::AXI_STATUS, 32'h6f);
		axw(sbs_pkg::AXI_STATUS, 32'h00, 4'h0, sbs_pkg::RESP_OKAY);
		rdk(sbs_pkg::AXI_STATUS, 32'h6f);
		// status, bank select and pc reached through the data port
		ca(6'h03);
		rdk(sbs_pkg::AXI_CORE_DATA, 32'h6f);
		ca(6'h04);
		wr(sbs_pkg::AXI_CORE_DATA, 32'hc2);
		rdk(sbs_pkg::AXI_BANKSEL, 32'h42);
		ca(6'h00);
		rdk(sbs_pkg::AXI_CORE_DATA, 32'haa);
		axw(8'h40, 32'h1, 4'hf, sbs_pkg::RESP_SLVERR);
		axr(8'h40, 32'h0, sbs_pkg::RESP_SLVERR);
		// second reset in mid-run
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rdk(sbs_pkg::AXI_PC, 32'h0);
		rdk(sbs_pkg::AXI_STATUS, 32'h18);
		wrap_up();
	end
endmodule // status_and_bank_select_bench
bind sbs_top sbs_top_properties u_props (.aclk, .aresetn, .wake_event,
	.other_reset_event, .sleep_instruction, .watchdog_clear_instruction,
	.watchdog_timeout, .alu_flags_we, .alu_zero, .alu_half_carry,
	.alu_carry, .pc_load, .pc_load_low, .return_pop, .return_addr,
	.program_counter, .status_out, .control_segment_select);
`default_nettype wire
